/* src/acp_pkg.sv */
// Shared constants and types of the arithmetic coprocessor.
package acp_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_BYTE0 = 8'he9;
  localparam logic [7:0] IDX_BYTE1 = 8'hea;
  localparam logic [7:0] IDX_BYTE2 = 8'heb;
  localparam logic [7:0] IDX_BYTE3 = 8'hec;
  localparam logic [7:0] IDX_BYTE4 = 8'hed;
  localparam logic [7:0] IDX_BYTE5 = 8'hee;
  localparam logic [7:0] IDX_CTRL  = 8'hef;

  // Offsets of the registers inside the block, counted from IDX_BYTE0.
  localparam logic [2:0] OFS_BYTE0 = 3'h0;
  localparam logic [2:0] OFS_BYTE1 = 3'h1;
  localparam logic [2:0] OFS_BYTE2 = 3'h2;
  localparam logic [2:0] OFS_BYTE3 = 3'h3;
  localparam logic [2:0] OFS_BYTE4 = 3'h4;
  localparam logic [2:0] OFS_BYTE5 = 3'h5;
  localparam logic [2:0] OFS_CTRL  = 3'h6;

  // Fields of the arith_control register.
  localparam int unsigned CTRL_ERR_BIT = 7;
  localparam int unsigned CTRL_OV_BIT  = 6;
  localparam int unsigned CTRL_DIR_BIT = 5;
  localparam int unsigned CTRL_SC_MSB  = 4;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;

  // Execution lengths in clock cycles.
  localparam logic [4:0] DIV32_CYCLES = 5'h11;
  localparam logic [4:0] DIV16_CYCLES = 5'h09;
  localparam logic [4:0] MUL_CYCLES   = 5'h0b;
  localparam logic [4:0] SHIFT_BASE   = 5'h02;
  localparam logic [4:0] NORM_BASE    = 5'h03;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_DIV32,
    OP_DIV16,
    OP_MUL,
    OP_SHIFT,
    OP_NORM
  } acp_op_t;

endpackage

/* src/acp_divider.sv */
// Unsigned divider of a 32-bit dividend by a 16-bit divisor.
`timescale 1ns/1ps
module acp_divider
  import acp_pkg::*;
(
  input  wire logic [31:0] i_dividend,
  input  wire logic [15:0] i_divisor,
  output logic      [31:0] o_quotient,
  output logic      [15:0] o_remainder,
  output logic             o_div_zero
);

  logic [31:0] divisor_wide;
  logic [31:0] rem_wide;

  assign divisor_wide = {16'h0000, i_divisor};
  assign o_div_zero   = (i_divisor == 16'h0000);

  // A zero divisor yields an all-ones quotient and keeps the low dividend word.
  always_comb begin
    if (o_div_zero) begin
      o_quotient  = 32'hffffffff;
      rem_wide    = {16'h0000, i_dividend[15:0]};
    end else begin
      o_quotient  = i_dividend / divisor_wide;
      rem_wide    = i_dividend % divisor_wide;
    end
  end

  assign o_remainder = rem_wide[15:0];

endmodule

/* src/acp_shifter.sv */
// Barrel shifter with leading-zero count for shift and normalize.
`timescale 1ns/1ps
module acp_shifter
  import acp_pkg::*;
(
  input  wire logic [31:0] i_value,
  input  wire logic        i_left,
  input  wire logic [4:0]  i_count,
  input  wire logic        i_norm,
  output logic      [31:0] o_result,
  output logic      [4:0]  o_lead,
  output logic             o_msb_set
);

  // An all-zero value counts as 31 leading zeros, the most the field can hold.
  always_comb begin
    o_lead = 5'h1f;
    for (int i = 0; i < 32; i++) begin
      if (i_value[i]) begin
        o_lead = 5'(31 - i);
      end
    end
  end

  assign o_msb_set = i_value[31];

  // Zeros enter at the vacated end in both directions.
  always_comb begin
    if (i_norm) begin
      o_result = i_value << o_lead;
    end else if (i_left) begin
      o_result = i_value << i_count;
    end else begin
      o_result = i_value >> i_count;
    end
  end

endmodule

/* src/acp_top.sv */
// Arithmetic coprocessor with its AHB-Lite register slave.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// RULE1: Divisions take 17 or 9, multiply 11 cycles.
// RULE2: Shift takes 3 to 18 cycles.
// RULE3: Normalize takes 3 to 19 cycles.
// RULE4: Results placed low byte first per operation.
// RULE5: Last read of byte 5 or 3 ends.
// RULE6: Normalize shifts left until top bit set.
// RULE7: Normalize writes shift count into field.
// RULE8: Shift direction bit, distance from count field.
// RULE9: Zeros enter at the vacated end.
// RULE10: Software must write a nonzero shift count.
// RULE11: Error detection from byte 0 write to last read.
// RULE12: Write during execution restarts and flags error.
// RULE13: Read during execution flags error, continues.
// RULE14: Error flag read-only, cleared by control read.
// RULE15: Overflow on zero divide, big product, normalized.
// RULE16: Operations without overflow clear the flag.
// RULE17: Software writes never change overflow flag.
// RULE18: Write order selects operation; last write starts.
// RULE19: Zero count selects normalize, else shift.
// RULE20: Unsigned arithmetic that overwrites its operands.
// RULE21: Cycle counts start at the starting write edge.
module acp_top
  import acp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp
);

  typedef struct packed {
    logic [5:0][7:0] opr;
    logic            err;
    logic            ov;
    logic            dir;
    logic [4:0]      sc;
    logic            detect;
    logic            busy;
    acp_op_t         op;
    acp_op_t         sel;
    logic [4:0]      cnt;
    logic            ap_valid;
    logic            ap_write;
    logic            ap_mapped;
    logic [2:0]      ap_ofs;
    logic [31:0]     hrdata;
  } acp_state_t;

  acp_state_t  st;
  acp_state_t  nx;

  logic        take;
  logic        mapped;
  logic [7:0]  addr_idx;
  logic [2:0]  addr_ofs;
  logic        wr;
  logic [7:0]  wbyte;
  logic        set_err;
  logic        clr_err;
  logic        done;
  acp_op_t     start_op;
  logic [4:0]  start_cycles;
  logic [7:0]  rvalue;
  logic [31:0] dividend;
  logic [31:0] quot;
  logic [15:0] rem;
  logic        div_zero;
  logic [31:0] product;
  logic [31:0] sh_result;
  logic [4:0]  lead;
  logic        msb_set;

  // The slave never stalls and never errors; reads are served from a flop.
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = st.hrdata;

  assign take     = i_hsel && i_htrans[1] && i_hready;
  assign addr_idx = i_haddr[9:2];
  assign addr_ofs = 3'(addr_idx - IDX_BYTE0);
  assign mapped   = (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'h0)
                    && (addr_idx >= IDX_BYTE0) && (addr_idx <= IDX_CTRL);
  assign wr       = st.ap_valid && st.ap_write && st.ap_mapped;
  assign wbyte    = i_hwdata[7:0];

  // Operands stay stable while busy because any write aborts the run.
  assign dividend = (st.op == OP_DIV16) ? {16'h0000, st.opr[1], st.opr[0]}
                                        : st.opr[3:0];
  assign product  = {st.opr[1], st.opr[0]} * {st.opr[5], st.opr[4]}; // RULE20

  acp_divider u_divider (
    .i_dividend  (dividend),
    .i_divisor   ({st.opr[5], st.opr[4]}),
    .o_quotient  (quot),
    .o_remainder (rem),
    .o_div_zero  (div_zero)
  );

  acp_shifter u_shifter (
    .i_value   (st.opr[3:0]),
    .i_left    (!st.dir),
    .i_count   (st.sc),
    .i_norm    (st.op == OP_NORM),
    .o_result  (sh_result),
    .o_lead    (lead),
    .o_msb_set (msb_set)
  );

  always_comb begin
    nx           = st;
    set_err      = 1'b0;
    clr_err      = 1'b0;
    done         = 1'b0;
    start_op     = OP_NONE;
    start_cycles = 5'h01;
    rvalue       = 8'h00;
    nx.ap_valid  = take;
    nx.ap_write  = i_hwrite;
    nx.ap_mapped = mapped;
    nx.ap_ofs    = addr_ofs;

    // Completion: results land once the cycle count has elapsed.
    if (st.busy) begin
      if (st.cnt == 5'h00) begin // RULE21
        done    = 1'b1;
        nx.busy = 1'b0;
        unique case (st.op)
          OP_DIV32: begin // RULE4
            nx.opr[3:0] = quot;
            nx.opr[5:4] = rem;
            nx.ov       = div_zero; // RULE15 RULE16
          end
          OP_DIV16: begin // RULE4
            nx.opr[1:0] = quot[15:0];
            nx.opr[3:2] = {BYTE_RESET, BYTE_RESET};
            nx.opr[5:4] = rem;
            nx.ov       = div_zero; // RULE15 RULE16
          end
          OP_MUL: begin // RULE4
            nx.opr[3:0] = product;
            nx.ov       = (product[31:16] != 16'h0000); // RULE15 RULE16
          end
          OP_SHIFT: begin // RULE8 RULE9
            nx.opr[3:0] = sh_result;
            nx.ov       = 1'b0; // RULE16
          end
          OP_NORM: begin // RULE6
            nx.opr[3:0] = sh_result;
            nx.sc       = lead; // RULE7
            nx.ov       = msb_set; // RULE15 RULE16
          end
          default: begin
            nx.busy = 1'b0;
          end
        endcase
      end else begin
        nx.cnt = st.cnt - 5'h01;
      end
    end

    // Write data phase: any write during a run aborts it.
    if (wr) begin
      if (st.busy) begin // RULE12
        set_err = 1'b1;
        nx.busy = 1'b0;
      end
      if (st.ap_ofs == OFS_CTRL) begin
        // The flag bits are not writable; only hardware moves them.
        nx.dir = wbyte[CTRL_DIR_BIT]; // RULE17
        nx.sc  = wbyte[CTRL_SC_MSB:0];
        if (wbyte[CTRL_SC_MSB:0] == 5'h00) begin // RULE19
          start_op     = OP_NORM;
          start_cycles = NORM_BASE + 5'((6'(lead) + 6'h01) >> 1); // RULE3
        end else begin
          start_op     = OP_SHIFT;
          start_cycles = SHIFT_BASE + 5'((6'(wbyte[4:0]) + 6'h01) >> 1); // RULE2
        end
      end else begin
        nx.opr[st.ap_ofs] = wbyte;
        unique case (st.ap_ofs)
          OFS_BYTE0: begin // RULE11 RULE18
            nx.detect = 1'b1;
            nx.sel    = OP_NONE;
          end
          OFS_BYTE1: begin // RULE18
            if (st.sel != OP_DIV32) begin
              nx.sel = OP_MUL;
            end
          end
          OFS_BYTE2, OFS_BYTE3: begin // RULE18
            nx.sel = OP_DIV32;
          end
          OFS_BYTE4: begin // RULE18
            if (st.sel != OP_DIV32) begin
              nx.sel = OP_DIV16;
            end
          end
          OFS_BYTE5: begin // RULE18
            start_op = st.sel;
          end
          default: begin
            nx.sel = st.sel;
          end
        endcase
        unique case (st.sel)
          OP_DIV32: start_cycles = DIV32_CYCLES; // RULE1
          OP_DIV16: start_cycles = DIV16_CYCLES; // RULE1
          default:  start_cycles = MUL_CYCLES; // RULE1
        endcase
      end
      if (start_op != OP_NONE) begin
        nx.busy = 1'b1;
        nx.op   = start_op;
        nx.cnt  = start_cycles - 5'h01;
      end
    end

    // Read address phase: the value reflects a write landing this edge.
    if (take && !i_hwrite && mapped) begin
      if (addr_ofs == OFS_CTRL) begin
        rvalue  = {st.err | set_err, nx.ov, nx.dir, nx.sc};
        clr_err = 1'b1; // RULE14
      end else begin
        rvalue = nx.opr[addr_ofs];
        if (nx.busy && st.detect) begin // RULE13
          set_err = 1'b1;
        end
        if (!nx.busy && nx.detect) begin // RULE5 RULE11
          if ((nx.op == OP_DIV32 || nx.op == OP_DIV16) ? (addr_ofs == OFS_BYTE5)
                                                        : (addr_ofs == OFS_BYTE3)) begin
            nx.detect = 1'b0;
          end
        end
      end
    end
    nx.hrdata = {24'h000000, rvalue};

    // A flag event in the clearing cycle wins over the clear.
    nx.err = (st.err && !clr_err) || set_err; // RULE14
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
      {st.err, st.ov, st.dir, st.sc} <= CTRL_RESET;
    end else begin
      st <= nx;
    end
  end

  // Cycles since the starting write, used only by the checks below.
  logic [5:0] elapsed;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      elapsed <= 6'h00;
    end else if (wr && start_op != OP_NONE) begin
      elapsed <= 6'h01;
    end else if (st.busy) begin
      elapsed <= elapsed + 6'h01;
    end
  end

  default clocking acp_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_div_mul_time: assert property ( // RULE1
    done |-> (st.op == OP_DIV32) ? (elapsed == 6'h11) :
             (st.op == OP_DIV16) ? (elapsed == 6'h09) :
             (st.op == OP_MUL)   ? (elapsed == 6'h0b) : 1'b1)
    else $error("Division or multiply finished at the wrong cycle.");

  a_shift_time: assert property ( // RULE2
    done && st.op == OP_SHIFT |-> elapsed == 6'(6'h02 + ((6'(st.sc) + 6'h01) >> 1)))
    else $error("Shift finished at the wrong cycle.");

  a_norm_time: assert property ( // RULE3
    done && st.op == OP_NORM |-> elapsed == 6'(6'h03 + ((6'(lead) + 6'h01) >> 1)))
    else $error("Normalize finished at the wrong cycle.");

  a_norm_result: assert property ( // RULE6
    done && st.op == OP_NORM && !wr && st.opr[3:0] != 32'h0 |=> st.opr[3][7])
    else $error("Normalize left the top bit clear.");

  a_norm_count: assert property ( // RULE7
    done && st.op == OP_NORM && !wr |=> st.sc == $past(lead))
    else $error("Normalize count not written back.");

  a_shift_fill: assert property ( // RULE9
    done && st.op == OP_SHIFT && !wr |=> (st.dir ? !st.opr[3][7] : !st.opr[0][0]))
    else $error("Shift did not fill with zero.");

  a_write_abort: assert property ( // RULE12
    st.busy && st.cnt != 5'h00 && wr |=> st.err && (st.busy == $past(start_op != OP_NONE)))
    else $error("Write during execution not flagged.");

  a_read_error: assert property ( // RULE13
    st.busy && st.cnt > 5'h01 && st.detect && !wr && take && !i_hwrite && mapped
      && addr_ofs != OFS_CTRL |=> st.err && st.busy)
    else $error("Read during execution not flagged or run stopped.");

  a_err_clear: assert property ( // RULE14
    take && !i_hwrite && mapped && addr_ofs == OFS_CTRL && !(st.busy && wr) |=> !st.err)
    else $error("Control read did not clear the error flag.");

  a_mul_overflow: assert property ( // RULE15
    done && st.op == OP_MUL |=> st.ov == ($past(product[31:16]) != 16'h0000))
    else $error("Multiply overflow flag wrong.");

  a_shift_ov_clear: assert property ( // RULE16
    done && st.op == OP_SHIFT |=> !st.ov)
    else $error("Shift did not clear overflow.");

endmodule

/* dv/acp_core_model.sv */
// Bus master model standing in for the processor core on the register bus.
`timescale 1ns/1ps
module acp_core_model
  import acp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic      [31:0] o_haddr,
  output logic      [1:0]  o_htrans,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic      [31:0] o_hwdata,
  output logic      [31:0] o_rdata,
  output int               o_nrd
);
  initial begin
    o_hsel   = 1'b1;
    o_haddr  = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize  = 3'h2;
    o_hwdata = 32'h0;
    o_rdata  = 32'h0;
    o_nrd    = 0;
  end

  // One single word transfer. In its address phase the data bus is inverted, so a
  // stale value can never pass for fresh write data.
  task automatic xfer(input logic wr, input logic [2:0] ofs, input logic [7:0] d);
    o_haddr  <= {22'h0, IDX_BYTE0 + {5'h0, ofs}, 2'h0};
    o_hwrite <= wr;
    o_htrans <= 2'h2;
    o_hwdata <= ~o_hwdata;
    @(posedge i_clk);
    while (i_hready !== 1'b1) @(posedge i_clk);
    o_htrans <= 2'h0;
    if (wr) o_hwdata <= {24'h0, d};
    @(posedge i_clk);
    while (i_hready !== 1'b1) @(posedge i_clk);
    if (!wr) o_rdata <= i_hrdata;
    if (!wr) o_nrd <= o_nrd + 1;
  endtask
endmodule

/* dv/test_multiply_divide_coprocessor.sv */
// Self-checking bench of the arithmetic coprocessor over its register bus.
`timescale 1ns/1ps
module test_multiply_divide_coprocessor;
  import acp_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        hsel, hwrite, hready, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [32:0] q[$];
  logic [32:0] e;
  logic [15:0] r = 16'h0058;
  logic [5:0]  c = 6'h00;
  int          nrd, seen, errors, n_compared;

  always #2.5 i_clk = ~i_clk;

  acp_top u_acp_top (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));
  acp_core_model u_core (.i_clk(i_clk), .i_hready(hready), .i_hrdata(hrdata),
    .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
    .o_hsize(hsize), .o_hwdata(hwdata), .o_rdata(rdata), .o_nrd(nrd));

  function automatic logic [15:0] lf(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic nx(output logic [15:0] v);
    r = lf(r);
    v = r;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wr(input logic [2:0] o, input logic [7:0] d);
    u_core.xfer(1'b1, o, d);
  endtask

  // A note with the top bit clear is a read whose data is not judged.
  task automatic rd(input logic [2:0] o, input logic [7:0] x, input logic k);
    q.push_back({k, 24'h0, x});
    u_core.xfer(1'b0, o, 8'h00);
  endtask

  // Loads operands in the order given by ord, waits out the run, then reads back.
  task automatic op(input logic [55:0] v, input logic [23:0] ord, input int n,
                    input int cyc, input logic [47:0] x, input int nb, input logic ov,
                    input logic er, input logic early);
    for (int i = 0; i < n; i++) wr(ord[4*i+:3], v[8*ord[4*i+:3]+:8]);
    wt(cyc - 1 - int'(early));
    if (early) rd(OFS_BYTE0, 8'h00, 1'b0);
    for (int i = 0; i < nb; i++) rd(3'(i), x[8*i+:8], 1'b1);
    rd(OFS_CTRL, {er, ov, c}, 1'b1);
    if (er) rd(OFS_CTRL, {1'b0, ov, c}, 1'b1);
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(negedge i_clk) begin
    if (nrd != seen) begin
      seen = nrd;
      e = q.pop_front();
      if (e[32]) begin
        n_compared++;
        if (rdata !== e[31:0] || hresp !== 1'b0) begin
          errors++;
          $display("[ERR] %0t read %h resp %b, expected %h", $time, rdata, hresp, e[31:0]);
        end
      end
    end
  end

  initial begin
    #50000;
    errors++;
    $display("[ERR] %0t run did not finish in time", $time);
    end_of_test();
  end

  initial begin
    logic [15:0] a, b, s;
    logic [31:0] dv, p;
    logic [4:0]  sc;
    int          z;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    // Every register and the unmapped slot above them read zero after reset.
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00, 1'b1);
    // Small and large products, early reads on odd passes, a restart on pass four.
    for (int i = 0; i < 6; i++) begin
      nx(a);
      nx(b);
      a = i < 2 ? a & 16'h0fff : a;
      b = i < 2 ? b & 16'h000f : b;
      p = a * b;
      op({8'h0, b, 16'h0, a}, 24'h55140, 4 + int'(i == 4), 11, {16'h0, p}, 4,
         p > 32'h0000ffff, i[0] | (i == 4), i[0]);
    end
    // The first pass divides by zero; later passes must clear the overflow again.
    for (int i = 0; i < 3; i++) begin
      nx(a);
      nx(b);
      nx(s);
      s = i == 0 ? 16'h0000 : s | 16'h0001;
      dv = {a, b};
      // A zero divisor gives an all-ones quotient and keeps the low dividend word.
      op({8'h0, s, dv}, 24'h543210, 6, 17,
         i == 0 ? {dv[15:0], 32'hffffffff} : {16'(dv % s), dv / s}, 6,
         i == 0, 1'b0, 1'b0);
      op({8'h0, s, 16'h0, a}, 24'h5410, 4, 9,
         i == 0 ? {a, 16'h0, 16'hffff} : {a % s, 16'h0, a / s}, 6,
         i == 0, 1'b0, 1'b0);
    end
    // Shortest and longest shifts both ways; the status bits written are ignored.
    for (int i = 0; i < 4; i++) begin
      nx(a);
      nx(b);
      sc = i[1] ? 5'h1f : 5'h01;
      c = {i[0], sc};
      dv = {a, b};
      p = i[0] ? dv >> sc : dv << sc;
      op({2'h3, c, 16'h0, dv}, 24'h63210, 5, 2 + (int'(sc) + 1) / 2, {16'h0, p}, 4,
         1'b0, 1'b0, 1'b0);
    end
    // A shift started by the control write alone runs with detection off.
    c = 6'h04;
    op({8'h04, 48'h0}, 24'h6, 1, 4, {16'h0, p << 4}, 4, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      nx(a);
      dv = i == 0 ? 32'h1 : i == 1 ? {1'b1, a, 15'h0} : i == 2 ? {9'h0, a, 7'h0} : 32'h0;
      z = 0;
      while (z < 31 && !dv[31 - z]) z++;
      c = {1'b0, 5'(z)};
      op({8'hc0, 16'h0, dv}, 24'h63210, 5, 3 + (z + 1) / 2, {16'h0, dv << z}, 4,
         dv[31], 1'b0, 1'b0);
    end
    // A byte5 write with no operation chosen only stores; an unmapped write is dropped.
    wr(OFS_BYTE0, 8'h12);
    wr(OFS_BYTE5, 8'h34);
    rd(OFS_BYTE5, 8'h34, 1'b1);
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00, 1'b1);
    rd(OFS_CTRL, {2'b00, c}, 1'b1);
    wt(2);
    end_of_test();
  end
endmodule
